/* File: hdl/liu_pkg.sv */
// constants, field layouts and carrier types for the line interface status bank
//Contract
//- strobe rising edge snapshots counter, then clears
//- snapshot is 16 bits, low and high bytes
//- rule select picks which violations count
//- live bit 5 shows driver monitor fault
//- live bit 4 shows pattern sync loss
//- live bit 1 shows pll unlocked, resets 1
//- live bit 0 shows signal lost, resets 1
//- latched bit 7 sets when buffer fills
//- latched bit 6 sets when buffer empties
//- latched bit 5 sets on driver monitor change
//- latched bit 4 sets on sync change
//- latched bit 3 sets on in-sync bit error
//- latched bit 2 sets on violation rising edge
//- latched bit 1 sets on pll lock change
//- latched bit 0 sets on signal change
//- write one clears latched bit; reset zero
//- irq active while latched and enabled
//- enable bits mirror latched bits, reset zero
//- control bit 7 enables ds3 clock driver
//- bits 6, 5 enable e3, sts1 drivers
//- bits 2:1 select alternate clock frequency
//- bit 0 enables alternate clock mode
//- enabled events pull interrupt pin low
//- one register set per port, 16 indices (0x40 bytes) apart
package liu_pkg;

  localparam int LIU_NPORTS = 4;

  // register indices inside one port set; byte address is four times the index
  localparam logic [3:0] LIU_IDX_CONFIG = 4'h0;
  localparam logic [3:0] LIU_IDX_RXCTRL = 4'h2;
  localparam logic [3:0] LIU_IDX_LIVE = 4'h3;
  localparam logic [3:0] LIU_IDX_LATCH = 4'h4;
  localparam logic [3:0] LIU_IDX_IRQEN = 4'h5;
  localparam logic [3:0] LIU_IDX_CNT_LO = 4'h6;
  localparam logic [3:0] LIU_IDX_CNT_HI = 4'h7;
  localparam logic [5:0] LIU_IDX_CLKADP = 6'h08;

  // config register fields
  localparam int LIU_CFG_SRST = 0;
  localparam int LIU_CFG_E3 = 7;
  // receive control fields
  localparam int LIU_RX_SNAP = 0;
  localparam int LIU_RX_RULE = 7;
  // live status fields
  localparam int LIU_LIVE_DRV = 5;
  localparam int LIU_LIVE_PAT = 4;
  localparam int LIU_LIVE_PLL = 1;
  localparam int LIU_LIVE_LOS = 0;
  // clock adapter fields
  localparam int LIU_CA_DS3_OE = 7;
  localparam int LIU_CA_E3_OE = 6;
  localparam int LIU_CA_STS1_OE = 5;
  localparam int LIU_CA_SEL_LSB = 1;
  localparam int LIU_CA_ALT_EN = 0;

  // reset values
  localparam logic [7:0] LIU_CONFIG_RST = 8'h00;
  localparam logic [7:0] LIU_RXCTRL_RST = 8'h00;
  localparam logic [7:0] LIU_LATCH_RST = 8'h00;
  localparam logic [7:0] LIU_IRQEN_RST = 8'h00;
  localparam logic [15:0] LIU_COUNT_RST = 16'h0000;
  localparam logic [7:0] LIU_CLKADP_RST = 8'h00;
  localparam logic [15:0] LIU_COUNT_MAX = 16'hFFFF;

  // alternate master clock frequency codes
  typedef enum logic [1:0] {
    LIU_ALT_19M44 = 2'b00,
    LIU_ALT_38M88 = 2'b01,
    LIU_ALT_77M76 = 2'b10,
    LIU_ALT_UNUSED = 2'b11
  } liu_alt_sel_t;

  // per-port event and status sources from the line logic
  typedef struct packed {
    logic jbuf_full;
    logic jbuf_empty;
    logic drv_fault;
    logic pattern_sync_loss;
    logic pattern_bit_error;
    logic pll_unlocked;
    logic signal_lost;
    logic bpv_invalid;
    logic bpv_same_pol;
    logic excess_zero;
  } liu_evt_in_t;

  localparam liu_evt_in_t LIU_EVT_RST = '{
    jbuf_full: 1'b0, jbuf_empty: 1'b0, drv_fault: 1'b0,
    pattern_sync_loss: 1'b0, pattern_bit_error: 1'b0,
    pll_unlocked: 1'b1, signal_lost: 1'b1,
    bpv_invalid: 1'b0, bpv_same_pol: 1'b0, excess_zero: 1'b0};

  // master clock pin driver controls
  typedef struct packed {
    logic ds3_clock_out_en;
    logic e3_clock_out_en;
    logic sts1_clock_out_en;
    logic [1:0] alt_clock_freq_sel;
    logic alt_clock_mode_en;
  } liu_clk_ctrl_t;

endpackage : liu_pkg

/* File: hdl/liu_status_irq_regs.sv */
// per-port status, latched event, interrupt enable and violation count registers
`timescale 1ns/1ps
module liu_status_irq_regs
  import liu_pkg::*;
#(
  parameter int NPORTS = LIU_NPORTS
)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // line logic sources
  input wire liu_evt_in_t [NPORTS-1:0] evt_i,
  // per-port controls back to the line logic
  output logic [NPORTS-1:0] port_soft_reset_o,
  output logic [NPORTS-1:0] e3_mode_o,
  // clock adapter controls
  output liu_clk_ctrl_t clk_ctrl_o,
  // shared interrupt pin
  output logic irq_n_o
);

  // register index from port number and local index
  function automatic logic [5:0] reg_index(input int port, input logic [3:0] idx);
    reg_index = {port[1:0], idx};
  endfunction : reg_index

  // counted violation for the selected rule
  function automatic logic cv_count(input liu_evt_in_t ev, input logic rule, input logic e3);
    if (rule)
    begin
      cv_count = e3 ? ev.bpv_same_pol : ev.bpv_invalid;
    end
    else
    begin
      cv_count = ev.bpv_invalid | ev.excess_zero;
    end
  endfunction : cv_count

  // bus state
  logic dp_wr;
  logic dp_rd;
  logic dp_mapped;
  logic [5:0] dp_idx;
  logic rd_done;
  logic addr_ok;
  logic wr_en;

  // port state
  liu_evt_in_t evt_s1 [NPORTS];
  liu_evt_in_t evt_s2 [NPORTS];
  liu_evt_in_t evt_s3 [NPORTS];
  logic [7:0] cfg [NPORTS];
  logic [7:0] rxctrl [NPORTS];
  logic [7:0] latched [NPORTS];
  logic [7:0] irq_en [NPORTS];
  logic [15:0] cv_cnt [NPORTS];
  logic [15:0] cv_snap [NPORTS];
  logic [NPORTS-1:0] snap_prev;
  logic [NPORTS-1:0] cv_ind;
  logic [7:0] clk_adp;

  // combinational per-port terms
  logic [7:0] live [NPORTS];
  logic [7:0] set_evt [NPORTS];
  logic [NPORTS-1:0] cv_hit;
  logic [NPORTS-1:0] snap_rise;
  logic [NPORTS-1:0] port_irq;
  logic [7:0] next_rdata;

  // address phase accepted
  assign addr_ok = hsel_i & htrans_i[1] & hready_i;
  assign wr_en = dp_wr & dp_mapped;

  // data phase tracking; reads take one wait state
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      dp_mapped <= 1'b0;
      dp_idx <= 6'h00;
    end
    else if (addr_ok)
    begin
      dp_wr <= hwrite_i;
      dp_rd <= ~hwrite_i;
      dp_mapped <= (haddr_i[31:8] == 24'h000000); // upper space unmapped
      dp_idx <= haddr_i[7:2];
    end
    else if (hreadyout_o)
    begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
    end
  end

  // read wait state and captured read data
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rd_done <= 1'b0;
      hrdata_o <= 32'h00000000;
    end
    else
    begin
      rd_done <= dp_rd & ~rd_done;
      if (dp_rd && !rd_done)
      begin
        hrdata_o <= {24'h000000, next_rdata};
      end
    end
  end

  // handshake: wait only in the first read data cycle; always okay
  assign hreadyout_o = ~(dp_rd & ~rd_done);
  assign hresp_o = 1'b0;

  // read multiplexer; unmapped indices read zero
  always_comb
  begin
    next_rdata = 8'h00;
    if (dp_mapped)
    begin
      if (dp_idx == LIU_IDX_CLKADP)
      begin
        next_rdata = clk_adp;
      end
      for (int p = 0; p < NPORTS; p++)
      begin
        if (dp_idx == reg_index(p, LIU_IDX_CONFIG)) next_rdata = cfg[p];
        if (dp_idx == reg_index(p, LIU_IDX_RXCTRL)) next_rdata = rxctrl[p];
        if (dp_idx == reg_index(p, LIU_IDX_LIVE)) next_rdata = live[p];
        if (dp_idx == reg_index(p, LIU_IDX_LATCH)) next_rdata = latched[p];
        if (dp_idx == reg_index(p, LIU_IDX_IRQEN)) next_rdata = irq_en[p];
        if (dp_idx == reg_index(p, LIU_IDX_CNT_LO)) next_rdata = cv_snap[p][7:0];
        if (dp_idx == reg_index(p, LIU_IDX_CNT_HI)) next_rdata = cv_snap[p][15:8];
      end
    end
  end

  // two-flop synchroniser plus history stage for edge detection
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int p = 0; p < NPORTS; p++)
      begin
        evt_s1[p] <= LIU_EVT_RST;
        evt_s2[p] <= LIU_EVT_RST;
        evt_s3[p] <= LIU_EVT_RST;
      end
    end
    else
    begin
      for (int p = 0; p < NPORTS; p++)
      begin
        evt_s1[p] <= evt_i[p];
        evt_s2[p] <= evt_s1[p];
        evt_s3[p] <= evt_s2[p];
      end
    end
  end

  // live view, event detection and counted violations
  always_comb
  begin
    for (int p = 0; p < NPORTS; p++)
    begin
      live[p] = 8'h00;
      live[p][LIU_LIVE_DRV] = evt_s2[p].drv_fault;
      live[p][LIU_LIVE_PAT] = evt_s2[p].pattern_sync_loss;
      live[p][LIU_LIVE_PLL] = evt_s2[p].pll_unlocked;
      live[p][LIU_LIVE_LOS] = evt_s2[p].signal_lost;
      cv_hit[p] = cv_count(evt_s2[p], rxctrl[p][LIU_RX_RULE], cfg[p][LIU_CFG_E3]);
      snap_rise[p] = rxctrl[p][LIU_RX_SNAP] & ~snap_prev[p];
      set_evt[p] = {
        evt_s2[p].jbuf_full & ~evt_s3[p].jbuf_full,
        evt_s2[p].jbuf_empty & ~evt_s3[p].jbuf_empty,
        evt_s2[p].drv_fault ^ evt_s3[p].drv_fault,
        evt_s2[p].pattern_sync_loss ^ evt_s3[p].pattern_sync_loss,
        evt_s2[p].pattern_bit_error & ~evt_s2[p].pattern_sync_loss,
        cv_hit[p] & ~cv_ind[p],
        evt_s2[p].pll_unlocked ^ evt_s3[p].pll_unlocked,
        evt_s2[p].signal_lost ^ evt_s3[p].signal_lost
      };
      port_irq[p] = |(latched[p] & irq_en[p]);
    end
  end

  // config register; soft reset clears everything but its own bit
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int p = 0; p < NPORTS; p++)
      begin
        cfg[p] <= LIU_CONFIG_RST;
      end
    end
    else
    begin
      for (int p = 0; p < NPORTS; p++)
      begin
        if (wr_en && dp_idx == reg_index(p, LIU_IDX_CONFIG))
        begin
          cfg[p] <= hwdata_i[7:0];
          if (hwdata_i[LIU_CFG_SRST])
          begin
            cfg[p] <= LIU_CONFIG_RST | 8'h01;
          end
        end
        else if (cfg[p][LIU_CFG_SRST])
        begin
          cfg[p][7:1] <= LIU_CONFIG_RST[7:1];
        end
      end
    end
  end

  // receive control, latched status and interrupt enables
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int p = 0; p < NPORTS; p++)
      begin
        rxctrl[p] <= LIU_RXCTRL_RST;
        latched[p] <= LIU_LATCH_RST;
        irq_en[p] <= LIU_IRQEN_RST;
      end
    end
    else
    begin
      for (int p = 0; p < NPORTS; p++)
      begin
        if (cfg[p][LIU_CFG_SRST])
        begin
          rxctrl[p] <= LIU_RXCTRL_RST;
          latched[p] <= LIU_LATCH_RST;
          irq_en[p] <= LIU_IRQEN_RST;
        end
        else
        begin
          if (wr_en && dp_idx == reg_index(p, LIU_IDX_RXCTRL))
          begin
            rxctrl[p] <= hwdata_i[7:0];
          end
          if (wr_en && dp_idx == reg_index(p, LIU_IDX_IRQEN))
          begin
            irq_en[p] <= hwdata_i[7:0];
          end
          // set wins over a write-one clear in the same cycle
          if (wr_en && dp_idx == reg_index(p, LIU_IDX_LATCH))
          begin
            latched[p] <= (latched[p] & ~hwdata_i[7:0]) | set_evt[p];
          end
          else
          begin
            latched[p] <= latched[p] | set_evt[p];
          end
        end
      end
    end
  end

  // violation counter, snapshot and strobe history
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      snap_prev <= '0;
      cv_ind <= '0;
      for (int p = 0; p < NPORTS; p++)
      begin
        cv_cnt[p] <= LIU_COUNT_RST;
        cv_snap[p] <= LIU_COUNT_RST;
      end
    end
    else
    begin
      for (int p = 0; p < NPORTS; p++)
      begin
        if (cfg[p][LIU_CFG_SRST])
        begin
          snap_prev[p] <= 1'b0;
          cv_ind[p] <= 1'b0;
          cv_cnt[p] <= LIU_COUNT_RST;
          cv_snap[p] <= LIU_COUNT_RST;
        end
        else
        begin
          snap_prev[p] <= rxctrl[p][LIU_RX_SNAP];
          cv_ind[p] <= cv_hit[p];
          if (snap_rise[p])
          begin
            cv_snap[p] <= cv_cnt[p];
            cv_cnt[p] <= {15'h0000, cv_hit[p]};
          end
          else if (cv_hit[p] && cv_cnt[p] != LIU_COUNT_MAX)
          begin
            cv_cnt[p] <= cv_cnt[p] + 16'h0001;
          end
        end
      end
    end
  end

  // shared clock adapter control
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      clk_adp <= LIU_CLKADP_RST;
    end
    else if (wr_en && dp_idx == LIU_IDX_CLKADP)
    begin
      clk_adp <= hwdata_i[7:0] & 8'hE7; // bits 4:3 reserved
    end
  end

  // clock adapter outputs
  assign clk_ctrl_o.ds3_clock_out_en = clk_adp[LIU_CA_DS3_OE];
  assign clk_ctrl_o.e3_clock_out_en = clk_adp[LIU_CA_E3_OE];
  assign clk_ctrl_o.sts1_clock_out_en = clk_adp[LIU_CA_STS1_OE];
  assign clk_ctrl_o.alt_clock_freq_sel = clk_adp[LIU_CA_SEL_LSB +: 2];
  assign clk_ctrl_o.alt_clock_mode_en = clk_adp[LIU_CA_ALT_EN];

  // per-port control outputs
  always_comb
  begin
    for (int p = 0; p < NPORTS; p++)
    begin
      port_soft_reset_o[p] = cfg[p][LIU_CFG_SRST];
      e3_mode_o[p] = cfg[p][LIU_CFG_E3];
    end
  end

  // registered active-low interrupt, all ports ORed
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_n_o <= 1'b1;
    end
    else
    begin
      irq_n_o <= ~(|port_irq);
    end
  end

endmodule : liu_status_irq_regs

/* File: testbench/liu_regs_monitor.sv */
// bus, control pin and interrupt pin checker for the status bank
`timescale 1ns/1ps
module liu_regs_monitor
  import liu_pkg::*;
#(
  parameter int NPORTS = LIU_NPORTS
)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire liu_evt_in_t [NPORTS-1:0] evt_i,
  input wire logic [NPORTS-1:0] port_soft_reset_o,
  input wire logic [NPORTS-1:0] e3_mode_o,
  input wire liu_clk_ctrl_t clk_ctrl_o,
  input wire logic irq_n_o
);
  logic aph;
  logic wr;
  logic land;
  logic wseen;
  logic [31:0] aq;
  logic [31:0] la;
  logic [31:0] ld;
  logic [7:0] hist;
  liu_evt_in_t [NPORTS-1:0] evd;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // track data phases, landed writes and recent source changes
  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
    begin
      aph <= 1'b0;
      wr <= 1'b0;
      land <= 1'b0;
      wseen <= 1'b0;
      aq <= 32'h0;
      la <= 32'h0;
      ld <= 32'h0;
      hist <= 8'h00;
      evd <= '{default: LIU_EVT_RST};
    end
    else
    begin
      if (hready_i)
      begin
        aph <= hsel_i & htrans_i[1];
        wr <= hwrite_i;
        aq <= haddr_i;
      end
      land <= aph & wr & hready_i;
      la <= aq;
      ld <= hwdata_i;
      evd <= evt_i;
      hist <= {hist[6:0], evd != evt_i};
      wseen <= wseen | land;
    end
  rd_wait_a: assert property (hsel_i && htrans_i[1] && hready_i && !hwrite_i
    |=> !hreadyout_o ##1 hreadyout_o) else $error("read wait state wrong");
  wr_nowait_a: assert property (aph && wr |-> hreadyout_o)
    else $error("write stalled");
  hresp_ok_a: assert property (hresp_o == 1'b0) else $error("error response");
  clk_wr_a: assert property (land && la == 32'h20
    |-> clk_ctrl_o == liu_clk_ctrl_t'({ld[7:5], ld[2:0]})) else $error("clock control wrong");
  srst_wr_a: assert property (land && la[31:8] == 24'h0 && la[5:2] == LIU_IDX_CONFIG
    && la[7:6] < NPORTS |-> port_soft_reset_o[la[7:6]] == ld[0]) else $error("soft reset wrong");
  irq_mask_a: assert property (!wseen |-> irq_n_o) else $error("irq before enable");
  irq_fall_a: assert property ($fell(irq_n_o) |-> (|hist) || $past(land)
    || $past(land, 2)) else $error("irq fell without cause");
  irq_rise_a: assert property ($rose(irq_n_o) |-> $past(land)
    || $past(land, 2)) else $error("irq rose without write");
  cover property (land && la == 32'h20);
  cover property ($fell(irq_n_o));
  cover property (hsel_i && htrans_i[1] && hready_i && !hwrite_i);
endmodule : liu_regs_monitor

bind liu_status_irq_regs liu_regs_monitor #(.NPORTS(NPORTS)) mon (.clk_sys_i(clk_sys_i),
  .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .evt_i(evt_i), .e3_mode_o(e3_mode_o),
  .port_soft_reset_o(port_soft_reset_o), .clk_ctrl_o(clk_ctrl_o), .irq_n_o(irq_n_o));

/* File: testbench/liu_status_irq_regs_tb.sv */
// self-checking bench for the line interface status register bank
`timescale 1ns/1ps
module liu_status_irq_regs_tb
  import liu_pkg::*;
;
  logic clk_sys_i;
  logic rst_i;
  logic hsel;
  logic hwrite;
  logic [1:0] htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic hready;
  logic hresp;
  logic irq_n;
  logic [3:0] srst;
  logic [3:0] e3m;
  liu_clk_ctrl_t cctl;
  liu_evt_in_t [3:0] evt;
  logic [7:0] cv [4] = '{8'hE1, 8'h43, 8'h24, 8'h9E};
  int error_cnt;
  int total_checks;
  liu_status_irq_regs uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .evt_i(evt),
    .port_soft_reset_o(srst), .e3_mode_o(e3m), .clk_ctrl_o(cctl), .irq_n_o(irq_n));
  // 40 MHz clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic test_done;
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // wait for hready with a bound
  task automatic rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1)
    begin
      error_cnt++;
      test_done();
    end
  endtask : rdy
  // one ahb-lite single transfer
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask : bus
  task automatic wr(input int p, input int i, input logic [7:0] d);
    bus(1'b1, 32'((p * 16 + i) * 4), {24'h0, d});
  endtask : wr
  task automatic rd(input int p, input int i, input logic [7:0] e);
    bus(1'b0, 32'((p * 16 + i) * 4), 32'h0);
    chk(q, {24'h0, e});
  endtask : rd
  // flip level sources of one port and let them settle
  task automatic tog(input int p, input logic [9:0] m);
    evt[p] <= liu_evt_in_t'(evt[p] ^ m);
    repeat (6) @(posedge clk_sys_i);
  endtask : tog
  // one-cycle pulses on port 0
  task automatic pulse(input logic [9:0] m, input int n);
    repeat (n)
    begin
      evt[0] <= liu_evt_in_t'(evt[0] | m);
      @(posedge clk_sys_i);
      evt[0] <= liu_evt_in_t'(evt[0] & ~m);
      @(posedge clk_sys_i);
    end
    repeat (4) @(posedge clk_sys_i);
  endtask : pulse
  task automatic irq(input logic e);
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, irq_n}, {31'h0, e});
  endtask : irq
  // main sequence
  initial
  begin
    rst_i = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    error_cnt = 0;
    total_checks = 0;
    evt = '{default: LIU_EVT_RST};
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    for (int p = 0; p < 4; p++)
    begin
      rd(p, 3, 8'h03);
      rd(p, 4, 8'h00);
      rd(p, 5, 8'h00);
      rd(p, 6, 8'h00);
      rd(p, 7, 8'h00);
    end
    rd(0, 8, 8'h00);
    irq(1'b1);
    tog(0, 10'h0D8);
    rd(0, 3, 8'h30);
    rd(0, 4, 8'h33);
    wr(0, 3, 8'hFF);
    wr(0, 4, 8'h01);
    rd(0, 4, 8'h32);
    rd(0, 3, 8'h30);
    wr(0, 4, 8'h32);
    tog(0, 10'h080);
    rd(0, 4, 8'h20);
    wr(0, 4, 8'h20);
    // buffer flags re-arm only after the condition goes away
    tog(0, 10'h300);
    rd(0, 4, 8'hC0);
    wr(0, 4, 8'hC0);
    rd(0, 4, 8'h00);
    tog(0, 10'h300);
    tog(0, 10'h300);
    rd(0, 4, 8'hC0);
    wr(0, 4, 8'hC0);
    // bit error ignored while out of sync
    pulse(10'h020, 1);
    rd(0, 4, 8'h00);
    tog(0, 10'h040);
    wr(0, 4, 8'h10);
    pulse(10'h020, 1);
    rd(0, 4, 8'h08);
    // rule 0: 259 invalid plus 2 excess zero, same polarity ignored
    pulse(10'h004, 259);
    pulse(10'h003, 2);
    wr(0, 2, 8'h01);
    rd(0, 6, 8'h05);
    rd(0, 7, 8'h01);
    rd(0, 4, 8'h0C);
    wr(0, 2, 8'h80);
    pulse(10'h007, 2);
    wr(0, 2, 8'h81);
    rd(0, 6, 8'h02);
    // rule 1 in e3 mode counts same polarity only
    wr(0, 0, 8'h80);
    // let the landed write settle before looking at the mode pin
    @(posedge clk_sys_i);
    chk({28'h0, e3m}, 32'h1);
    wr(0, 2, 8'h80);
    pulse(10'h002, 3);
    pulse(10'h004, 1);
    wr(0, 2, 8'h81);
    rd(0, 6, 8'h03);
    rd(0, 7, 8'h00);
    // interrupt from each other port, masked and cleared
    for (int p = 1; p < 4; p++)
    begin
      wr(p, 5, 8'h02);
      tog(p, 10'h010);
      irq(1'b0);
      wr(p, 5, 8'h00);
      irq(1'b1);
      wr(p, 5, 8'h02);
      irq(1'b0);
      wr(p, 4, 8'h02);
      irq(1'b1);
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(0, 8, cv[k]);
      rd(0, 8, cv[k] & 8'hE7);
      chk(32'(cctl), {26'h0, cv[k][7:5], cv[k][2:0]});
    end
    // unmapped places read zero and take no write
    bus(1'b1, 32'h100, 32'hFF);
    rd(0, 0, 8'h80);
    wr(0, 1, 8'hFF);
    rd(0, 1, 8'h00);
    // soft reset holds the port set at default
    wr(2, 5, 8'hFF);
    wr(2, 0, 8'h01);
    // let the landed write settle before looking at the reset pins
    @(posedge clk_sys_i);
    chk({28'h0, srst}, 32'h4);
    rd(2, 5, 8'h00);
    wr(2, 0, 8'h00);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    chk(32'(cctl), 32'h0);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rd(0, 8, 8'h00);
    test_done();
  end
endmodule : liu_status_irq_regs_tb
